// ==== leec_pkg.sv ====
// constants for the latched eeprom byte-mode host controller
package leec_pkg;
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          ADDR_W        = 13;
  localparam int          COL_W         = 5;
  localparam int          DATA_W        = 8;
  localparam logic [7:0]  ERASE_DATA    = 8'hFF;
  // timing figures in their own units
  localparam int          SETUP_NS      = 50;
  localparam int          CLR_SETUP_NS  = 1000;
  localparam int          HOLD_NS       = 50;
  localparam int          READ_REC_US   = 1;
  localparam int          READ_ACC_NS   = 250;
  localparam int          BYTE_STD_MS   = 9;
  localparam int          BYTE_FAST_MS  = 1;
  localparam int          CLEAR_MS      = 10;
  localparam int          NS_PER_S      = 1_000_000_000;
  // least times round up, none below one cycle, except CSETUP_CYC, which truncates
  localparam int SETUP_CYC  = (SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CSETUP_CYC = CLR_SETUP_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int HOLD_CYC   = (HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int READ_REC_CYC = READ_REC_US * (CLK_HZ / 1_000_000);
  localparam int ACC_CYC    = (READ_ACC_NS * (CLK_HZ / 1_000_000) + 999) / 1000
                              + 1;
  localparam int BYTE_STD_CYC  = BYTE_STD_MS * (CLK_HZ / 1000);
  localparam int BYTE_FAST_CYC = BYTE_FAST_MS * (CLK_HZ / 1000);
  localparam int CLEAR_CYC     = CLEAR_MS * (CLK_HZ / 1000);
  localparam int CNT_W         = 24;
  typedef enum logic [1:0] {LEEC_READ, LEEC_ERASE, LEEC_WRITE, LEEC_CLEAR}
    leec_cmd_e;
endpackage

// ==== leec_sync.sv ====
// two-flop synchroniser for pin inputs, one per bit
`timescale 1ns/1ps
`default_nettype none
module leec_sync #(
  parameter int W = 8
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
          meta[g] <= 1'b0;
          o_q[g]  <= 1'b0;
        end else begin
          meta[g] <= i_d[g];
          o_q[g]  <= meta[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== leec_host.sv ====
// host controller driving the latched byte-wide eeprom pins
//
// Contract
// [RULE_01] read: select low, output drive low, strobe high, clear high.
// [RULE_02] select high puts device in standby; no operation starts.
// [RULE_03] a byte must be erased before new data is written.
// [RULE_04] erase: address, select low, drive high, clear high, ones, strobe.
// [RULE_05] device latches all inputs on the strobe falling edge.
// [RULE_06] byte erase completes within ten milliseconds, standard variant.
// [RULE_07] write uses erase sequence with real data on the byte lines.
// [RULE_08] byte operation takes 1 ms fast variant, 9 ms standard.
// [RULE_09] one byte operation leaves every other byte unchanged.
// [RULE_10] select low, clear low, drive high, strobe low erases all bytes.
// [RULE_11] no write or erase while supply below 3 V.
// [RULE_12] between 3 V and 5 V only a real strobe fall triggers.
// [RULE_13] writing blocked unless select low and output drive high.
// [RULE_14] device latches address, data, select and drive inputs.
// [RULE_15] 8192 bytes; five column lines, eight row lines.
// [RULE_16] after hold time host may change pins until recovery ends.
// [RULE_17] host waits 1 us after strobe rise before reading.
// [RULE_18] update: erase, wait full time, write, wait full time.
// [RULE_19] device ignores inputs until operation and recovery finish.
`timescale 1ns/1ps
`default_nettype none
module leec_host (
  input  wire logic                         i_mclk,
  input  wire logic                         i_rstn,
  input  wire logic                         i_fast_part,
  input  wire logic                         i_req,
  input  wire leec_pkg::leec_cmd_e          i_cmd,
  input  wire logic [leec_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [leec_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic [leec_pkg::DATA_W-1:0]  i_byte_lines,
  output logic                              o_busy,
  output logic                              o_done,
  output logic [leec_pkg::DATA_W-1:0]       o_rdata,
  output logic [leec_pkg::COL_W-1:0]        o_column_select_lines,
  output logic [leec_pkg::ADDR_W-leec_pkg::COL_W-1:0] o_row_select_lines,
  output logic [leec_pkg::DATA_W-1:0]       o_byte_lines,
  output logic                              o_byte_lines_oen,
  output logic                              o_select_n,
  output logic                              o_out_drive_n,
  output logic                              o_strobe_n,
  output logic                              o_array_clear_n
);
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_RECOV,
                            S_RDACC, S_DONE} leec_state_e;
  leec_state_e                   state;
  leec_pkg::leec_cmd_e           cmd;
  logic [leec_pkg::CNT_W-1:0]    cnt;
  logic [leec_pkg::DATA_W-1:0]   bl_sync;
  logic [leec_pkg::CNT_W-1:0]    byte_time;

  leec_sync #(.W(leec_pkg::DATA_W)) u_sync (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .i_d    (i_byte_lines),
    .o_q    (bl_sync)
  );

  always_comb begin
    if (i_fast_part) begin
      byte_time = leec_pkg::CNT_W'(leec_pkg::BYTE_FAST_CYC); // [RULE_08]
    end else begin
      byte_time = leec_pkg::CNT_W'(leec_pkg::BYTE_STD_CYC); // [RULE_06]
    end
  end

  // sequencer: one request at a time, busy covers the whole recovery
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= S_IDLE;
      cmd   <= leec_pkg::LEEC_READ;
      cnt   <= '0;
    end else begin
      case (state)
        S_IDLE: begin
          if (i_req) begin
            cmd   <= i_cmd;
            state <= (i_cmd == leec_pkg::LEEC_READ) ? S_RDACC : S_SETUP;
            cnt   <= (i_cmd == leec_pkg::LEEC_READ)
                     ? leec_pkg::CNT_W'(leec_pkg::ACC_CYC + 2)
                     : (i_cmd == leec_pkg::LEEC_CLEAR)
                     ? leec_pkg::CNT_W'(leec_pkg::CSETUP_CYC)
                     : leec_pkg::CNT_W'(leec_pkg::SETUP_CYC);
          end
        end
        S_SETUP: begin
          if (cnt <= 1) begin
            state <= S_STROBE; // [RULE_05]
            cnt   <= (cmd == leec_pkg::LEEC_CLEAR)
                     ? leec_pkg::CNT_W'(leec_pkg::CLEAR_CYC) : byte_time;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        S_STROBE: begin
          // the strobe low time is the operation time on this part
          if (cnt <= 1) begin
            state <= S_HOLD; // [RULE_18]
            cnt   <= leec_pkg::CNT_W'(leec_pkg::HOLD_CYC);
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        S_HOLD: begin
          if (cnt <= 1) begin
            state <= S_RECOV; // [RULE_17]
            cnt   <= leec_pkg::CNT_W'(leec_pkg::READ_REC_CYC);
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        S_RECOV: begin
          if (cnt <= 1) begin
            state <= S_DONE; // [RULE_19]
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        S_RDACC: begin
          // two extra cycles pay for the synchroniser on the byte lines
          if (cnt <= 1) begin
            state <= S_DONE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        S_DONE: begin
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // pin drive, all from flops; standby whenever idle
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_select_n       <= 1'b1; // [RULE_02]
      o_out_drive_n    <= 1'b1;
      o_strobe_n       <= 1'b1;
      o_array_clear_n  <= 1'b1;
      o_byte_lines_oen <= 1'b1;
      o_byte_lines     <= '0;
      o_column_select_lines <= '0;
      o_row_select_lines    <= '0;
    end else if (state == S_IDLE && i_req) begin
      o_column_select_lines <= i_addr[leec_pkg::COL_W-1:0]; // [RULE_15]
      o_row_select_lines    <= i_addr[leec_pkg::ADDR_W-1:leec_pkg::COL_W];
      o_select_n <= 1'b0;
      if (i_cmd == leec_pkg::LEEC_READ) begin
        o_out_drive_n    <= 1'b0; // [RULE_01]
        o_array_clear_n  <= 1'b1;
        o_byte_lines_oen <= 1'b1;
      end else begin
        o_out_drive_n    <= 1'b1; // [RULE_13]
        o_array_clear_n  <= (i_cmd != leec_pkg::LEEC_CLEAR); // [RULE_10]
        o_byte_lines_oen <= 1'b0;
        o_byte_lines     <= (i_cmd == leec_pkg::LEEC_WRITE)
                            ? i_wdata : leec_pkg::ERASE_DATA; // [RULE_04]
      end
    end else if (state == S_SETUP && cnt <= 1) begin
      o_strobe_n <= 1'b0; // [RULE_12]
    end else if (state == S_STROBE && cnt <= 1) begin
      o_strobe_n <= 1'b1; // [RULE_07]
    end else if (state == S_HOLD && cnt <= 1) begin
      o_select_n       <= 1'b1; // [RULE_16]
      o_out_drive_n    <= 1'b1;
      o_array_clear_n  <= 1'b1;
      o_byte_lines_oen <= 1'b1;
    end else if (state == S_RDACC && cnt <= 1) begin
      o_select_n    <= 1'b1;
      o_out_drive_n <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= '0;
      o_done  <= 1'b0;
      o_busy  <= 1'b0;
    end else begin
      if (state == S_RDACC && cnt <= 1) begin
        o_rdata <= bl_sync;
      end
      o_done <= (state == S_DONE);
      o_busy <= (state == S_IDLE) ? i_req : (state != S_DONE);
    end
  end
endmodule
`default_nettype wire

// ==== leec_host_props.sv ====
// pin-level assertions for the eeprom host controller
`timescale 1ns/1ps
`default_nettype none
module leec_host_props (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_fast_part,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_byte_lines_oen,
  input wire logic o_select_n,
  input wire logic o_out_drive_n,
  input wire logic o_strobe_n,
  input wire logic o_array_clear_n
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  logic [23:0] low_cnt;
  // counts strobe-low cycles; a repetition could not span the pulse
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) low_cnt <= 24'h0;
    else low_cnt <= o_strobe_n ? 24'h0 : low_cnt + 24'h1;
  end
  sequence s_recover;
    (o_busy && o_select_n)[*8];
  endsequence
  a_select_setup: assert property (
    $fell(o_strobe_n) |-> !$past(o_select_n))
    else $error("strobe fell without select set up");
  a_strobe_width: assert property (
    $rose(o_strobe_n) && o_array_clear_n
    |-> low_cnt == (i_fast_part ? 24'h2710 : 24'h15F90))
    else $error("byte strobe width wrong");
  a_write_mode: assert property (
    !o_strobe_n |-> !o_select_n && o_out_drive_n)
    else $error("strobe low outside write mode");
  a_host_drives: assert property (
    !o_strobe_n && o_array_clear_n |-> !o_byte_lines_oen)
    else $error("byte lines not driven during strobe");
  a_read_release: assert property (
    !o_out_drive_n |-> o_byte_lines_oen && o_strobe_n && o_array_clear_n)
    else $error("read with host driving or strobing");
  a_done_pulse: assert property (o_done |-> !o_busy ##1 !o_done)
    else $error("done not a single idle pulse");
  a_hold_recover: assert property (
    $rose(o_strobe_n) |-> !o_select_n ##1 s_recover)
    else $error("hold or recovery broken");
  a_standby_idle: assert property (!o_busy |-> o_select_n && o_strobe_n)
    else $error("pins active while idle");
endmodule
bind leec_host leec_host_props u_props (.i_mclk, .i_rstn, .i_fast_part,
  .o_busy, .o_done, .o_byte_lines_oen, .o_select_n, .o_out_drive_n,
  .o_strobe_n, .o_array_clear_n);
`default_nettype wire

// ==== leec_eeprom_model.sv ====
// behavioural latched byte-wide eeprom on the far side of the pins
`timescale 1ns/1ps
`default_nettype none
module leec_eeprom_model #(
  parameter realtime BYTE_NS = 1.0e6
) (
  input  wire logic        i_select_n,
  input  wire logic        i_out_drive_n,
  input  wire logic        i_strobe_n,
  input  wire logic        i_array_clear_n,
  input  wire logic [12:0] i_addr,
  input  wire logic [7:0]  i_byte_lines,
  output logic      [7:0]  o_data,
  output logic             o_drive,
  output logic             o_late
);
  logic [7:0]  mem [8192];
  logic [12:0] a_q;
  logic [7:0]  d_q;
  logic        clr_q;
  logic        arm;
  realtime     t_fall;
  realtime     t_rise;
  initial begin
    for (int i = 0; i < 8192; i++) mem[i] = i[7:0] ^ 8'h3C;
    arm = 1'b0;
    o_late = 1'b0;
    t_fall = -1.0e9;
    t_rise = -1.0e9;
  end
  // only a real fall arms; a strobe already low starts nothing
  always @(negedge i_strobe_n) begin
    // supply is always in range here, so only the pin levels gate
    arm = !i_select_n && i_out_drive_n;
    a_q = i_addr;
    d_q = i_byte_lines;
    clr_q = i_array_clear_n;
    t_fall = $realtime;
  end
  always @(posedge i_strobe_n) begin
    // the power-up rise has no fall before it and opens no recovery
    if (t_fall > t_rise) t_rise = $realtime;
    // a pulse shorter than the byte time leaves the cell untouched
    if (arm && $realtime - t_fall >= BYTE_NS) begin
      if (!clr_q) mem = '{default: 8'hFF};
      else if (d_q === 8'hFF) mem[a_q] = 8'hFF;
      else mem[a_q] = mem[a_q] & d_q;
    end
    arm = 1'b0;
  end
  assign o_drive = !i_select_n && !i_out_drive_n && i_strobe_n
    && i_array_clear_n;
  assign o_data = mem[i_addr];
  always @(negedge i_out_drive_n) begin
    if ($realtime - t_rise < 1000.0) o_late = 1'b1;
  end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the eeprom host controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        i_mclk = 1'b0;
  logic        i_rstn = 1'b0;
  logic        i_req  = 1'b0;
  logic [1:0]  cmd    = 2'h0;
  logic [12:0] addr   = 13'h0;
  logic [7:0]  wdata  = 8'h0;
  logic [7:0]  o_rdata, o_byte_lines, dev_data, pins, row;
  logic [4:0]  col;
  logic        o_busy, o_done, oen, sel_n, oe_n, we_n, clr_n, dev_drive, late;
  int          errors = 0;
  int          n_tests = 0;
  // rows: command, address, data, expected read byte
  logic [30:0] rows [7] = '{{2'h0, 13'h0021, 8'h00, 8'h1D},
    {2'h1, 13'h0021, 8'hFF, 8'h00}, {2'h0, 13'h0021, 8'h00, 8'hFF},
    {2'h2, 13'h0021, 8'hA5, 8'h00}, {2'h0, 13'h0021, 8'h00, 8'hA5},
    {2'h0, 13'h0020, 8'h00, 8'h1C}, {2'h0, 13'h0022, 8'h00, 8'h1E}};
  always #50 i_mclk = ~i_mclk;
  // released lines toggle every clock so stale data cannot pass
  assign pins = !oen ? o_byte_lines : dev_drive ? dev_data
    : {4{i_mclk, !i_mclk}};
  leec_host u_dut (.i_mclk, .i_rstn, .i_fast_part(1'b1), .i_req,
    .i_cmd(leec_pkg::leec_cmd_e'(cmd)), .i_addr(addr), .i_wdata(wdata),
    .i_byte_lines(pins), .o_busy, .o_done, .o_rdata,
    .o_column_select_lines(col), .o_row_select_lines(row), .o_byte_lines,
    .o_byte_lines_oen(oen), .o_select_n(sel_n), .o_out_drive_n(oe_n),
    .o_strobe_n(we_n), .o_array_clear_n(clr_n));
  leec_eeprom_model u_mem (.i_select_n(sel_n), .i_out_drive_n(oe_n),
    .i_strobe_n(we_n), .i_array_clear_n(clr_n), .i_addr({row, col}),
    .i_byte_lines(pins), .o_data(dev_data), .o_drive(dev_drive),
    .o_late(late));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_done;
    int n;
    for (n = 0; n < 20000 && o_done !== 1'b1; n++) @(negedge i_mclk);
    check({7'h0, o_done}, 8'h01);
  endtask
  task automatic start(input logic [1:0] c, input logic [12:0] a,
                       input logic [7:0] d);
    @(negedge i_mclk);
    cmd = c;
    addr = a;
    wdata = d;
    i_req = 1'b1;
    @(negedge i_mclk);
  endtask
  task automatic finish_test;
    if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge i_mclk);
    i_rstn = 1'b1;
    check({3'h0, sel_n, oe_n, we_n, clr_n, oen}, 8'h1F);
    foreach (rows[i]) begin
      start(rows[i][30:29], rows[i][28:16], rows[i][15:8]);
      i_req = 1'b0;
      wait_done();
      if (rows[i][30:29] == 2'h0) begin
        check(o_rdata, rows[i][7:0]);
      end
    end
    // a write asked for while the erase runs must be dropped
    start(2'h1, 13'h1FFF, 8'hFF);
    cmd = 2'h2;
    wdata = 8'h00;
    @(negedge i_mclk);
    i_req = 1'b0;
    check({7'h0, o_busy}, 8'h01);
    wait_done();
    start(2'h0, 13'h1FFF, 8'h00);
    i_req = 1'b0;
    wait_done();
    check(o_rdata, 8'hFF);
    // reset cut into a running erase: standby at once, cell untouched
    start(2'h1, 13'h0040, 8'hFF);
    i_req = 1'b0;
    repeat (20) @(negedge i_mclk);
    i_rstn = 1'b0;
    repeat (4) @(negedge i_mclk);
    check({1'b0, o_busy, o_done, sel_n, oe_n, we_n, clr_n, oen},
          8'h1F);
    i_rstn = 1'b1;
    // strobe rose at reset, so the read waits out the recovery
    repeat (12) @(negedge i_mclk);
    start(2'h0, 13'h0040, 8'h00);
    i_req = 1'b0;
    wait_done();
    check(o_rdata, 8'h7C);
    check({7'h0, late}, 8'h00);
    finish_test();
  end
  initial begin
    #8_000_000;
    errors++;
    finish_test();
  end
endmodule
`default_nettype wire
